/* File: verilog/bjd_core.sv */
// jump decoder and program counter sequencer
// What this block does
// - Far jump loads PC 10..8 from opcode top bits, 7..0 from operand.
// - Far jump loads PC bit 11 from the memory bank flip-flop.
// - Bank flip-flop holds value of the latest bank-select instruction.
// - Indirect jump reads in-page byte at accumulator, puts it in PC 7..0.
// - Taken conditional jump replaces PC 7..0 only, upper bits kept.
// - Untaken conditional jump adds two to PC; always two cycles.
// - Carry-clear jump branches when carry is zero.
// - Interrupt-low jump branches when interrupt pin is low.
// - Accumulator jump branches when any accumulator bit is one.
// - Timer jump branches when the timer flag is set.
// - Timer jump clears the timer flag after sampling it, taken or not.
// - First-test jump branches when first test input is high.
// - Second-test-high jump branches when second test input is high.
// - Second-test-low jump branches when second test input is low.
`timescale 1ns/100ps
`include "bjd_cfg.svh"
module bjd_core #(
    parameter int CYC_DIV = `BJD_CYC_DIV,
    parameter logic [7:0] OP_ACC_NZ = `BJD_OP_ACC_NZ,
    parameter logic [7:0] OP_TMR = `BJD_OP_TMR
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // program memory
    output logic [11:0] pmem_addr,
    input wire logic [7:0] pmem_data,
    output logic cyc_en,
    // condition sources from core logic
    input wire logic carry_flag,
    input wire logic [7:0] acc,
    input wire logic timer_flag,
    output logic timer_flag_clr,
    // pins
    input wire logic irq_pin_n,
    input wire logic first_test_input,
    input wire logic second_test_input,
    // bank select from the rest of the decoder
    input wire logic bank_sel_valid,
    input wire logic bank_sel_value,
    // status
    output logic [11:0] pc,
    output logic jump_taken,
    output logic other_op_valid,
    output logic [7:0] other_op_code
);
    ////////////////////////////////////////////////////////////////////
    logic [1:0] rst_sync_reg;
    logic rst_n;
    logic [1:0] irq_sync_reg;
    logic [1:0] t0_sync_reg;
    logic [1:0] t1_sync_reg;
    logic [7:0] div_reg;
    bjd_pkg::bjd_state_t state_reg;
    bjd_pkg::bjd_kind_t kind;
    bjd_pkg::bjd_kind_t kind_reg;
    logic [7:0] op_reg;
    logic cond_true;
    logic cond_reg;
    logic [11:0] pc_reg;
    logic [11:0] pc_inc;
    logic [11:0] pc_next;
    logic [11:0] addr_reg;
    logic memory_bank_flipflop_reg;
    logic taken_reg;
    logic tclr_reg;
    logic other_reg;
    logic [7:0] other_code_reg;

    // reset release through two flops
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // pin synchronisers; only the second stage is read
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_sync_reg <= 2'h3;
            t0_sync_reg <= 2'h0;
            t1_sync_reg <= 2'h0;
        end else begin
            irq_sync_reg <= {irq_sync_reg[0], irq_pin_n};
            t0_sync_reg <= {t0_sync_reg[0], first_test_input};
            t1_sync_reg <= {t1_sync_reg[0], second_test_input};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // machine cycle divider, one-cycle enable
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_reg <= 8'h00;
        end else if (div_reg == 8'(CYC_DIV - 1)) begin
            div_reg <= 8'h00;
        end else begin
            div_reg <= div_reg + 8'h01;
        end
    end
    assign cyc_en = (div_reg == 8'(CYC_DIV - 1));

    bjd_cond_eval #(
        .OP_ACC_NZ(OP_ACC_NZ),
        .OP_TMR(OP_TMR)
    ) u_cond (
        .opcode(pmem_data),
        .carry_flag(carry_flag),
        .irq_pin_n_s(irq_sync_reg[1]),
        .acc(acc),
        .timer_flag(timer_flag),
        .first_test_s(t0_sync_reg[1]),
        .second_test_s(t1_sync_reg[1]),
        .kind(kind),
        .cond_true(cond_true),
        .is_timer_op()
    );

    ////////////////////////////////////////////////////////////////////
    // bank flip-flop follows the last bank select
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            memory_bank_flipflop_reg <= 1'b0;
        end else if (bank_sel_valid) begin
            memory_bank_flipflop_reg <= bank_sel_value;
        end
    end

    // new program counter at the end of the operand cycle
    assign pc_inc = pc_reg + 12'h001;
    always_comb begin
        pc_next = pc_inc; // fall through: second increment
        case (kind_reg)
            bjd_pkg::BJD_K_FAR:
                pc_next = {memory_bank_flipflop_reg,
                    op_reg[`BJD_OP_PAGE_MSB:`BJD_OP_PAGE_LSB],
                    pmem_data};
            bjd_pkg::BJD_K_IND:
                pc_next = {pc_reg[11:8], pmem_data};
            bjd_pkg::BJD_K_COND: begin
                if (cond_reg) begin
                    pc_next = {pc_reg[11:8], pmem_data};
                end
            end
            default: pc_next = pc_inc;
        endcase
    end

    // sequencer: jumps take two machine cycles, others one
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= bjd_pkg::BJD_ST_FETCH;
            kind_reg <= bjd_pkg::BJD_K_OTHER;
            op_reg <= 8'h00;
            cond_reg <= 1'b0;
            pc_reg <= `BJD_PC_RESET;
            addr_reg <= `BJD_PC_RESET;
        end else if (cyc_en) begin
            case (state_reg)
                bjd_pkg::BJD_ST_FETCH: begin
                    op_reg <= pmem_data;
                    kind_reg <= kind;
                    pc_reg <= pc_inc;
                    // sampled once here, before any clear
                    cond_reg <= cond_true;
                    if (kind == bjd_pkg::BJD_K_OTHER) begin
                        addr_reg <= pc_inc;
                    end else begin
                        state_reg <= bjd_pkg::BJD_ST_OPERAND;
                        // indirect reads in the page of the operand
                        if (kind == bjd_pkg::BJD_K_IND) begin
                            addr_reg <= {pc_inc[11:8], acc};
                        end else begin
                            addr_reg <= pc_inc;
                        end
                    end
                end
                bjd_pkg::BJD_ST_OPERAND: begin
                    state_reg <= bjd_pkg::BJD_ST_FETCH;
                    pc_reg <= pc_next;
                    addr_reg <= pc_next;
                end
                default: state_reg <= bjd_pkg::BJD_ST_FETCH;
            endcase
        end
    end

    // one-cycle pulses: taken jump, timer flag clear, other opcode
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            taken_reg <= 1'b0;
            tclr_reg <= 1'b0;
            other_reg <= 1'b0;
            other_code_reg <= 8'h00;
        end else begin
            taken_reg <= 1'b0;
            tclr_reg <= 1'b0;
            other_reg <= 1'b0;
            if (cyc_en && state_reg == bjd_pkg::BJD_ST_OPERAND) begin
                taken_reg <= (kind_reg != bjd_pkg::BJD_K_COND) || cond_reg;
                // clear after the flag was read, taken or not
                tclr_reg <= (kind_reg == bjd_pkg::BJD_K_COND)
                    && (op_reg == OP_TMR);
            end
            if (cyc_en && state_reg == bjd_pkg::BJD_ST_FETCH
                    && kind == bjd_pkg::BJD_K_OTHER) begin
                other_reg <= 1'b1;
                other_code_reg <= pmem_data;
            end
        end
    end

    assign pmem_addr = addr_reg;
    assign pc = pc_reg;
    assign jump_taken = taken_reg;
    assign timer_flag_clr = tclr_reg;
    assign other_op_valid = other_reg;
    assign other_op_code = other_code_reg;

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    logic opd_end;
    assign opd_end = cyc_en && state_reg == bjd_pkg::BJD_ST_OPERAND;

    a_far_target: assert property (
        opd_end && kind_reg == bjd_pkg::BJD_K_FAR |=>
        pc_reg[10:0] == {$past(op_reg[7:5]), $past(pmem_data)})
        else $error("far jump target wrong");
    a_far_bank: assert property (
        opd_end && kind_reg == bjd_pkg::BJD_K_FAR |=>
        pc_reg[11] == $past(memory_bank_flipflop_reg))
        else $error("far jump bank bit wrong");
    a_bank_hold: assert property (
        bank_sel_valid ##1 !bank_sel_valid [*2] |->
        memory_bank_flipflop_reg == $past(bank_sel_value, 2))
        else $error("bank flip-flop lost select");
    a_ind_addr: assert property (
        cyc_en && state_reg == bjd_pkg::BJD_ST_FETCH
        && kind == bjd_pkg::BJD_K_IND |=>
        pmem_addr == {pc_reg[11:8], $past(acc)})
        else $error("indirect read address wrong");
    a_cond_taken: assert property (
        opd_end && kind_reg == bjd_pkg::BJD_K_COND && cond_reg |=>
        pc_reg == {$past(pc_reg[11:8]), $past(pmem_data)} && jump_taken)
        else $error("taken branch target wrong");
    a_cond_fall: assert property (
        opd_end && kind_reg == bjd_pkg::BJD_K_COND && !cond_reg |=>
        pc_reg == $past(pc_reg) + 12'h001 && !jump_taken)
        else $error("untaken branch did not skip operand");
    a_two_cycles: assert property (
        cyc_en && state_reg == bjd_pkg::BJD_ST_FETCH
        && kind != bjd_pkg::BJD_K_OTHER |=>
        state_reg == bjd_pkg::BJD_ST_OPERAND)
        else $error("jump did not take two cycles");
    a_carry_cond: assert property (
        cyc_en && state_reg == bjd_pkg::BJD_ST_FETCH
        && pmem_data == `BJD_OP_CARRY_CLR |=> cond_reg == !$past(carry_flag))
        else $error("carry condition inverted");
    a_tmr_clear: assert property (
        opd_end && kind_reg == bjd_pkg::BJD_K_COND && op_reg == OP_TMR
        |=> timer_flag_clr ##1 !timer_flag_clr)
        else $error("timer flag not cleared");
    a_clr_only_tmr: assert property (
        timer_flag_clr |-> op_reg == OP_TMR
        && state_reg == bjd_pkg::BJD_ST_FETCH)
        else $error("stray timer flag clear");
endmodule : bjd_core

/* File: inc/bjd_cfg.svh */
// constants for the jump decoder: opcodes, field positions and timing
`ifndef BJD_CFG_SVH
`define BJD_CFG_SVH

// machine cycle: system clocks per machine cycle
`define BJD_CYC_DIV 4
`define BJD_PC_RESET 12'h000
// direct jump: low five opcode bits fixed, top three carry address
`define BJD_OP_FAR_LOW 5'h04
`define BJD_OP_FAR_LSB 0
`define BJD_OP_FAR_MSB 4
`define BJD_OP_PAGE_LSB 5
`define BJD_OP_PAGE_MSB 7
// fixed single opcodes
`define BJD_OP_IND 8'hb3
`define BJD_OP_CARRY_CLR 8'he6
`define BJD_OP_IRQ_LOW 8'h86
`define BJD_OP_T0_HIGH 8'h36
`define BJD_OP_T1_HIGH 8'h56
`define BJD_OP_T1_LOW 8'h46
// opcodes without a fixed encoding here; arbitrary defaults
`define BJD_OP_ACC_NZ 8'h9e
`define BJD_OP_TMR 8'h1e

`endif

/* File: inc/bjd_pkg.sv */
// types shared by the jump decoder modules
package bjd_pkg;
    // sequencer: opcode fetch cycle, operand cycle
    typedef enum logic {
        BJD_ST_FETCH,
        BJD_ST_OPERAND
    } bjd_state_t;
    // decoded instruction class
    typedef enum logic [1:0] {
        BJD_K_OTHER,
        BJD_K_FAR,
        BJD_K_IND,
        BJD_K_COND
    } bjd_kind_t;
endpackage : bjd_pkg

/* File: verilog/bjd_cond_eval.sv */
// opcode classifier and branch condition evaluation
`timescale 1ns/100ps
`include "bjd_cfg.svh"
module bjd_cond_eval #(
    parameter logic [7:0] OP_ACC_NZ = `BJD_OP_ACC_NZ,
    parameter logic [7:0] OP_TMR = `BJD_OP_TMR
) (
    // opcode in
    input wire logic [7:0] opcode,
    // condition sources, already synchronised
    input wire logic carry_flag,
    input wire logic irq_pin_n_s,
    input wire logic [7:0] acc,
    input wire logic timer_flag,
    input wire logic first_test_s,
    input wire logic second_test_s,
    // results
    output bjd_pkg::bjd_kind_t kind,
    output logic cond_true,
    output logic is_timer_op
);
    logic acc_nz;

    // accumulator non-zero: any bit set
    assign acc_nz = |acc;
    assign is_timer_op = (opcode == OP_TMR);

    // classify and pick the condition
    always_comb begin
        kind = bjd_pkg::BJD_K_COND;
        cond_true = 1'b0;
        case (opcode)
            `BJD_OP_IND: kind = bjd_pkg::BJD_K_IND;
            `BJD_OP_CARRY_CLR: cond_true = ~carry_flag;
            `BJD_OP_IRQ_LOW: cond_true = ~irq_pin_n_s;
            `BJD_OP_T0_HIGH: cond_true = first_test_s;
            `BJD_OP_T1_HIGH: cond_true = second_test_s;
            `BJD_OP_T1_LOW: cond_true = ~second_test_s;
            OP_ACC_NZ: cond_true = acc_nz;
            OP_TMR: cond_true = timer_flag;
            default: begin
                // any opcode with the fixed low pattern is a far jump
                if (opcode[`BJD_OP_FAR_MSB:`BJD_OP_FAR_LSB]
                        == `BJD_OP_FAR_LOW) begin
                    kind = bjd_pkg::BJD_K_FAR;
                end else begin
                    kind = bjd_pkg::BJD_K_OTHER;
                end
            end
        endcase
    end
endmodule : bjd_cond_eval

/* File: sim/bjd_pmem_model.sv */
// program memory model that feeds the jump decoder one byte per address
`timescale 1ns/100ps
module bjd_pmem_model #(
    parameter int LAT = 2
) (
    // clock
    input wire logic clk,
    // fetch port
    input wire logic [11:0] addr,
    output logic [7:0] data
);
    logic [7:0] mem [0:4095];
    logic [11:0] addr_reg = 12'h000;
    int age_reg = 0;
    ////////////////////////////////////////////////////////////////////////
    // count clocks since the address moved; slow answers need LAT of them
    always_ff @(posedge clk) begin
        addr_reg <= addr;
        if (addr !== addr_reg) begin
            age_reg <= 0;
        end else if (age_reg < LAT) begin
            age_reg <= age_reg + 1;
        end
    end
    // not ready yet: 5a or a5 picked by the age parity, so stale data never fits
    always @* begin
        if (age_reg >= LAT && addr === addr_reg) begin
            data = mem[addr];
        end else begin
            data = age_reg[0] ? 8'ha5 : 8'h5a;
        end
    end
    initial begin
        for (int i = 0; i < 4096; i++) begin
            mem[i] = 8'h00;
        end
    end
endmodule : bjd_pmem_model

/* File: sim/tb_branch_jump_decoder.sv */
// testbench for the jump decoder with a program memory model
`timescale 1ns/100ps
module tb_branch_jump_decoder;
    logic sys_clk = 1'b0, nrst = 1'b0, cyc_en, timer_flag_clr, jump_taken;
    logic carry_flag = 1'b0, timer_flag = 1'b0, irq_pin_n = 1'b1;
    logic first_test_input = 1'b0, second_test_input = 1'b0;
    logic bank_sel_valid = 1'b0, bank_sel_value = 1'b0, other_op_valid;
    logic [7:0] acc = 8'h00, pmem_data, other_op_code;
    logic [11:0] pmem_addr, pc, park = 12'h000;
    logic [7:0] ops [7] = '{8'he6, 8'h86, 8'h9e, 8'h1e, 8'h36, 8'h56, 8'h46};
    int fails = 0, n_checks = 0, clr_cnt = 0;
    always #2 sys_clk = ~sys_clk;
    bjd_core #(.CYC_DIV(4)) uut (.sys_clk(sys_clk), .nrst(nrst),
        .pmem_addr(pmem_addr), .pmem_data(pmem_data), .cyc_en(cyc_en),
        .carry_flag(carry_flag), .acc(acc), .timer_flag(timer_flag),
        .timer_flag_clr(timer_flag_clr), .irq_pin_n(irq_pin_n),
        .first_test_input(first_test_input),
        .second_test_input(second_test_input),
        .bank_sel_valid(bank_sel_valid), .bank_sel_value(bank_sel_value),
        .pc(pc), .jump_taken(jump_taken), .other_op_valid(other_op_valid),
        .other_op_code(other_op_code));
    bjd_pmem_model #(.LAT(2)) pm (.clk(sys_clk), .addr(pmem_addr),
        .data(pmem_data));
    ////////////////////////////////////////////////////////////////////////
    // timer flag as the timer holds it; cleared on request, pulses counted
    always @(posedge sys_clk) begin
        if (timer_flag_clr === 1'b1) begin
            timer_flag <= 1'b0;
            clr_cnt <= clr_cnt + 1;
        end
    end
    task automatic tally_and_finish;
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    // bytes mirrored in both banks so a bank flip never strands the loop
    task automatic put(input logic [11:0] a, input logic [7:0] v);
        pm.mem[{1'b0, a[10:0]}] = v;
        pm.mem[{1'b1, a[10:0]}] = v;
    endtask : put
    task automatic sel(input logic v);
        @(posedge sys_clk);
        #1 bank_sel_valid = 1'b1;
        bank_sel_value = v;
        @(posedge sys_clk);
        #1 bank_sel_valid = 1'b0;
    endtask : sel
    ////////////////////////////////////////////////////////////////////////
    // place op at a, redirect the parking loop to it, then count ncyc
    // machine cycles: the parking jump takes two, the tested code the rest
    task automatic run(input logic [7:0] op, input logic [11:0] a,
        input logic [7:0] arg, input logic [11:0] exp, input int ncyc,
        input logic tk, input int nother);
        int i;
        int n;
        int n_other;
        put(exp, {exp[10:8], 5'h04});
        put(exp + 12'h001, exp[7:0]);
        put(a, op);
        put(a + 12'h001, arg);
        // rewrite the loop only while its opcode is still unfetched
        for (i = 0; i < 40; i++) begin
            @(posedge sys_clk);
            #1;
            if (pmem_addr[10:0] === park[10:0]) break;
        end
        if (i == 40) begin
            fails++;
            tally_and_finish();
        end
        clr_cnt = 0;
        put(park, {a[10:8], 5'h04});
        put(park + 12'h001, a[7:0]);
        // cyc_en high now means the next edge is a machine-cycle edge
        n = (cyc_en === 1'b1) ? 1 : 0;
        n_other = 0;
        for (i = 0; i < 80 && n < ncyc; i++) begin
            @(posedge sys_clk);
            #1;
            if (other_op_valid === 1'b1) n_other++;
            if (cyc_en === 1'b1) n++;
        end
        if (n < ncyc) begin
            fails++;
            tally_and_finish();
        end
        // after the last machine-cycle edge pc and the pulse show one clock
        @(posedge sys_clk);
        #1;
        if (other_op_valid === 1'b1) n_other++;
        check(pc, exp);
        check(jump_taken, tk);
        check(n_other, nother);
        park = exp;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask : run
    task automatic t_far;
        run(8'ha4, 12'h050, 8'hc0, 12'h5c0, 4, 1'b1, 0);
        $display("test far done");
    endtask : t_far
    task automatic t_bank;
        @(posedge sys_clk);
        #1 bank_sel_valid = 1'b1;
        bank_sel_value = 1'b0;
        @(posedge sys_clk);
        #1 bank_sel_value = 1'b1;
        @(posedge sys_clk);
        #1 bank_sel_valid = 1'b0;
        run(8'h44, 12'h060, 8'h30, 12'ha30, 4, 1'b1, 0);
        sel(1'b0);
        $display("test bank done");
    endtask : t_bank
    task automatic t_ind;
        acc = 8'h40;
        put(12'h140, 8'h77);
        run(8'hb3, 12'h130, 8'h00, 12'h177, 4, 1'b1, 0);
        $display("test indirect done");
    endtask : t_ind
    // a plain opcode is reported once and steps pc by one only
    task automatic t_other;
        put(12'h0a2, 8'hc0);
        run(8'h07, 12'h0a0, 8'h04, 12'h0c0, 5, 1'b1, 1);
        check(other_op_code, 8'h07);
        $display("test other done");
    endtask : t_other
    // own condition set to t, every other source opposite, so a wrong
    // condition choice lands on the wrong loop, except second-test-low for k below 5
    task automatic t_cond(input int k, input logic t);
        logic [6:0] v;
        logic [11:0] a, tgt;
        v = {7{~t}};
        v[k] = t;
        a = 12'h300 + 12'(k * 32) + (t ? 12'h010 : 12'h000);
        tgt = 12'h3e0 + 12'(k * 4) + (t ? 12'h002 : 12'h000);
        carry_flag = ~v[0];
        irq_pin_n = ~v[1];
        acc = v[2] ? 8'h80 : 8'h00;
        timer_flag = v[3];
        first_test_input = v[4];
        second_test_input = v[5];
        run(ops[k], a, tgt[7:0], t ? tgt : a + 12'h002,
            4, t, 0);
        check(clr_cnt, (k == 3) ? 1 : 0);
        $display("test cond %0d %0d done", k, t);
    endtask : t_cond
    ////////////////////////////////////////////////////////////////////////
    // main sequence: reset, parking loop at zero, then the scenarios
    initial begin
        #1;
        put(12'h000, 8'h04);
        put(12'h001, 8'h00);
        repeat (12) @(posedge sys_clk);
        #1 nrst = 1'b1;
        // let the internal reset copy release before the first select
        repeat (4) @(posedge sys_clk);
        sel(1'b0);
        t_far();
        t_bank();
        t_ind();
        t_other();
        for (int k = 0; k < 7; k++) begin
            t_cond(k, 1'b1);
            t_cond(k, 1'b0);
        end
        tally_and_finish();
    end
endmodule : tb_branch_jump_decoder
